/* File: verilog/cmd_input_qualifier.sv */
`default_nettype none

module cmd_input_qualifier
    import cmd_qual_pkg::*;
(
    input  wire logic      ref_clk,        // Memory clock, rising crossing
    input  wire logic      rst,            // Synchronous reset, active high
    input  wire logic      cke,            // Clock enable pin
    input  wire ctl_pins_s pins,           // Chip select, strobes, termination control
    input  wire logic      any_row_open,   // Some bank holds an open row
    input  wire logic      sr_request,     // Last command before cke low was refresh
    input  wire logic      mr1_odt_off,    // Mode register 1 termination disabled
    input  wire logic      mr2_odt_off,    // Mode register 2 termination disabled
    output cmd_e           cmd_q,          // Accepted command, one cycle
    output logic           cmd_valid_q,    // Accepted command is not deselect or nop
    output pwr_e           pwr_state_q,    // Present power state
    output buf_en_s        buf_en,         // Input buffer and driver enables
    output logic           odt_on_q        // Termination active on data, strobes, masks
);

    // ************************************************************
    // Input sampling
    // ************************************************************
    ctl_pins_s pins_q;
    cmd_e      cmd_d;
    logic      refresh_seen_q;

    // Every control input sampled on the rising crossing only
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            pins_q <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, odt: 1'b0};
        else if (buf_en.cmd_buf)
            pins_q <= pins;
        else
            pins_q <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                        odt: buf_en.odt_buf ? pins.odt : 1'b0};
    end

    cmd_decode u_dec
    (
        .pins (pins_q),
        .cmd  (cmd_d)
    );

    // ************************************************************
    // Command output
    // ************************************************************
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            cmd_q       <= CMD_DESELECT;
            cmd_valid_q <= 1'b0;
        end
        else
        begin
            cmd_q       <= cmd_d;
            cmd_valid_q <= (cmd_d != CMD_DESELECT) && (cmd_d != CMD_NOP);
        end
    end

    // Refresh with cke low and no row open selects self-refresh rather than power-down
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            refresh_seen_q <= 1'b0;
        else
            refresh_seen_q <= sr_request;
    end

    // ************************************************************
    // Power state
    // ************************************************************
    // Self-refresh exit is taken on cke high at the next rising edge; the clock may
    // have been stopped, so no prior edge count is relied on
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            pwr_state_q <= PWR_ACTIVE;
        else
        begin
            unique case (pwr_state_q)
                PWR_ACTIVE:
                    if (!cke)
                    begin
                        if (any_row_open)
                            pwr_state_q <= PWR_ACT_PD;
                        else if (refresh_seen_q)
                            pwr_state_q <= PWR_SELF_REF;
                        else
                            pwr_state_q <= PWR_PRE_PD;
                    end
                PWR_PRE_PD, PWR_ACT_PD:
                    if (cke)
                        pwr_state_q <= PWR_ACTIVE;
                PWR_SELF_REF:
                    if (cke)
                        pwr_state_q <= PWR_ACTIVE;
            endcase
        end
    end

    // ************************************************************
    // Buffer enables
    // ************************************************************
    always_comb
    begin
        buf_en.cke_buf = 1'b1;
        buf_en.clk_buf = (pwr_state_q != PWR_SELF_REF);
        buf_en.odt_buf = (pwr_state_q != PWR_SELF_REF);
        buf_en.cmd_buf = (pwr_state_q == PWR_ACTIVE) && cke;
        buf_en.out_drv = (pwr_state_q == PWR_ACTIVE) && cke;
    end

    // ************************************************************
    // Termination
    // ************************************************************
    // Disable in both mode registers together, and self-refresh, each override the pin
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            odt_on_q <= 1'b0;
        else
            odt_on_q <= pins_q.odt && !(mr1_odt_off && mr2_odt_off)
                        && (pwr_state_q != PWR_SELF_REF);
    end

endmodule : cmd_input_qualifier

`default_nettype wire

/* File: verilog/cmd_qual_pkg.sv */
`default_nettype none

package cmd_qual_pkg;

    // ************************************************************
    // Timing constants
    // ************************************************************
    localparam int unsigned CLK_PERIOD_PS     = 8000;
    localparam int unsigned TREFI_EXT_NS      = 3900;
    localparam int unsigned TREFI_EXT_CYC     = (TREFI_EXT_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned REFRESH_EXT_MS    = 32;
    localparam int unsigned TAA_DOWNBIN_PS    = 13125;                 // Down-binned ceiling
    localparam int unsigned TAA_DOWNBIN_CYC   =
        (TAA_DOWNBIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ************************************************************
    // Mode register field positions
    // ************************************************************
    localparam int unsigned MR2_ASR_BIT       = 6;
    localparam int unsigned MR2_SRT_BIT       = 7;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [3:0] {
        CMD_DESELECT, CMD_NOP, CMD_MRS, CMD_REFRESH, CMD_PRECHARGE,
        CMD_ACTIVATE, CMD_WRITE, CMD_READ, CMD_ZQCAL
    } cmd_e;

    typedef enum logic [1:0] {
        PWR_ACTIVE, PWR_PRE_PD, PWR_ACT_PD, PWR_SELF_REF
    } pwr_e;

    // Control pins as sampled at the crossing, active-low fields in *_n
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic odt;
    } ctl_pins_s;

    // Buffer enables that the power state drives
    typedef struct packed {
        logic clk_buf;
        logic cke_buf;
        logic odt_buf;
        logic cmd_buf;
        logic out_drv;
    } buf_en_s;

endpackage : cmd_qual_pkg

`default_nettype wire

/* File: verilog/cmd_decode.sv */
`default_nettype none

module cmd_decode
    import cmd_qual_pkg::*;
(
    input  wire ctl_pins_s pins,     // Sampled control pins
    output cmd_e           cmd       // Decoded command
);

    // ************************************************************
    // Command decode
    // ************************************************************
    // Chip select forms the top bit of the code; high masks everything
    always_comb
    begin
        unique case ({pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n})
            4'b0000: cmd = CMD_MRS;
            4'b0001: cmd = CMD_REFRESH;
            4'b0010: cmd = CMD_PRECHARGE;
            4'b0011: cmd = CMD_ACTIVATE;
            4'b0100: cmd = CMD_WRITE;
            4'b0101: cmd = CMD_READ;
            4'b0110: cmd = CMD_ZQCAL;
            4'b0111: cmd = CMD_NOP;
            default: cmd = CMD_DESELECT;
        endcase
    end

endmodule : cmd_decode

`default_nettype wire

/* File: testbench/cmd_qual_properties.sv */
`default_nettype none
module cmd_qual_properties
    import cmd_qual_pkg::*;
(
    input wire logic      ref_clk,      // Clock
    input wire logic      rst,          // Reset
    input wire logic      cke,          // Clock enable
    input wire ctl_pins_s pins,         // Pins
    input wire logic      any_row_open, // Open row
    input wire logic      sr_request,   // Refresh entry
    input wire logic      mr1_odt_off,  // Mode 1
    input wire logic      mr2_odt_off,  // Mode 2
    input wire cmd_e      cmd_q,        // Command
    input wire logic      cmd_valid_q,  // Valid
    input wire pwr_e      pwr_state_q,  // Power
    input wire buf_en_s   buf_en,       // Enables
    input wire logic      odt_on_q      // Termination
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] up_q; // Depth-2 history
    // Past samples mean nothing until two edges clear of reset
    always_ff @(posedge ref_clk) up_q <= rst ? 2'h0 : {up_q[0], 1'b1};
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_cs_masks:
        assert property (up_q[1] && $past(pins.cs_n, 2) |-> cmd_q == CMD_DESELECT && !cmd_valid_q)
        else $error("select high not ignored");
    a_read_decode:
        assert property (up_q[1] && $past(cke, 2) && $past(pwr_state_q, 2) == PWR_ACTIVE
            && $past(pins[4:1], 2) == 4'h5 |-> cmd_q == CMD_READ && cmd_valid_q)
        else $error("read not decoded");
    a_low_power_mask:
        assert property (up_q[1] && $past(pwr_state_q, 2) != PWR_ACTIVE |-> cmd_q == CMD_DESELECT)
        else $error("command in low power");
    a_act_pd_entry:
        assert property (pwr_state_q == PWR_ACTIVE && !cke && any_row_open
            |=> pwr_state_q == PWR_ACT_PD)
        else $error("no active power-down");
    a_sr_entry:
        assert property (up_q[0] && pwr_state_q == PWR_ACTIVE && !cke && !any_row_open
            && sr_request && $past(sr_request) |=> pwr_state_q == PWR_SELF_REF)
        else $error("no self-refresh");
    a_cke_exit:
        assert property (pwr_state_q != PWR_ACTIVE && cke |=> pwr_state_q == PWR_ACTIVE)
        else $error("no exit");
    a_sr_buffers:
        assert property (pwr_state_q == PWR_SELF_REF && !cke |-> buf_en == 5'h08)
        else $error("self-refresh buffers");
    a_odt_gate:
        assert property (up_q[1] && ($past(cke, 2) || $past(pwr_state_q, 2) != PWR_ACTIVE)
            |-> odt_on_q == ($past(pins.odt, 2) && $past(pwr_state_q, 2) != PWR_SELF_REF
            && $past(pwr_state_q) != PWR_SELF_REF
            && !($past(mr1_odt_off) && $past(mr2_odt_off))))
        else $error("termination wrong");
endmodule : cmd_qual_properties
`default_nettype wire

/* File: testbench/mc_model.sv */
`default_nettype none
module mc_model
    import cmd_qual_pkg::*;
(
    input  wire logic     ref_clk, // Clock
    output var logic      cke,     // Clock enable
    output var ctl_pins_s pins     // Pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // Deselected, clocks on
    initial
    begin
        cke  = 1'b1;
        pins = 5'h1e;
    end
    // Mode register 2 image for manual extended-range self-refresh
    localparam logic [7:0] MR2_EXT_SR = 8'(1 << MR2_SRT_BIT);
    // Hot-case refresh spacing; double rate halves the normal gap
    task automatic ref_gap();
        repeat (TREFI_EXT_CYC - 3) @(posedge ref_clk);
    endtask : ref_gap
    // One command cycle, 1 ns past the edge
    task automatic put(input logic k, input ctl_pins_s p);
        @(posedge ref_clk);
        #1;
        cke  = k; // Low with a command only when refusal is wanted
        pins = p;
    endtask : put
endmodule : mc_model
`default_nettype wire

/* File: testbench/testbench.sv */
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_mismatch++; \
    $display("mismatch t=%0t got %h exp %h", $time, a, e); end end
module testbench
    import cmd_qual_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic      ref_clk = 1'b0, rst = 1'b1, any_row_open = 1'b0, sr_request = 1'b0;
    logic      mr1_odt_off = 1'b0, mr2_odt_off = 1'b0, cke, cmd_valid_q, odt_on_q;
    ctl_pins_s pins;
    cmd_e      cmd_q;
    pwr_e      pwr_state_q;
    buf_en_s   buf_en;
    int        n_mismatch = 0, comparisons = 0;
    cmd_e      tab [8] = '{CMD_MRS, CMD_REFRESH, CMD_PRECHARGE, CMD_ACTIVATE,
                           CMD_WRITE, CMD_READ, CMD_ZQCAL, CMD_NOP};
    always #4 ref_clk = ~ref_clk; // 125 MHz
    cmd_input_qualifier i_cmd_input_qualifier (.*);
    mc_model            i_mc_model (.*);
    task automatic put(input logic k, input ctl_pins_s p);
        i_mc_model.put(k, p);
    endtask : put
    // Command, then two idle cycles until the answer shows
    task automatic run(input ctl_pins_s p, input cmd_e c, input logic o);
        put(1'b1, p);
        put(1'b1, 5'h1e);
        put(1'b1, 5'h1e);
        `CHK(cmd_q, c)
        `CHK(odt_on_q, o)
        `CHK(cmd_valid_q, c != CMD_DESELECT)
    endtask : run
    // Low-power entry, a refused read with termination, then exit
    task automatic lp(input logic row, sr, input pwr_e st, input logic [4:0] be, o);
        any_row_open = row;
        sr_request = sr;
        put(1'b1, 5'h1e);
        put(1'b0, 5'h1e);
        put(1'b0, 5'h0b);
        `CHK(pwr_state_q, st)
        `CHK(buf_en, be)
        put(1'b0, 5'h1e);
        put(1'b0, 5'h1e);
        `CHK(cmd_q, CMD_DESELECT)
        `CHK(odt_on_q, o)
        put(1'b1, 5'h1e);
        put(1'b1, 5'h1e);
        `CHK(pwr_state_q, PWR_ACTIVE)
    endtask : lp
    task automatic end_sim();
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    // Main sequence: back-to-back codes, masking, termination, power
    initial
    begin
        repeat (20) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        put(1'b1, 5'h1e);
        `CHK(buf_en, 5'h1f)
        for (int i = 0; i < 10; i++)
        begin
            put(1'b1, {1'b0, i[2:0], 1'b0});
            if (i > 1)
                `CHK(cmd_q, tab[i-2])
        end
        run(5'h1a, CMD_DESELECT, 1'b0);
        run(5'h0b, CMD_READ, 1'b1);
        mr1_odt_off = 1'b1;
        run(5'h0b, CMD_READ, 1'b1);
        mr2_odt_off = 1'b1;
        run(5'h0b, CMD_READ, 1'b0);
        mr1_odt_off = 1'b0;
        mr2_odt_off = 1'b0;
        run(5'h02, CMD_REFRESH, 1'b0);
        i_mc_model.ref_gap();
        run(5'h02, CMD_REFRESH, 1'b0);
        lp(1'b1, 1'b0, PWR_ACT_PD, 5'h1c, 1'b1);
        lp(1'b0, 1'b0, PWR_PRE_PD, 5'h1c, 1'b1);
        lp(1'b0, 1'b1, PWR_SELF_REF, 5'h08, 1'b0);
        end_sim();
    end
endmodule : testbench
bind cmd_input_qualifier cmd_qual_properties i_cmd_qual_properties (.*);
`default_nettype wire
